/* src/tpc_top.sv */
// Timer PWM channel: counter, channel value buffer, PWM output and flag.
// Assumes an AXI4-Lite master on aclk; the PWM pin is output only.
//
// Function
// - Edge mode with polarity 0 goes high on overflow and low on compare, reversed at 1.
// - Edge mode with a zero channel value never enters the active level.
// - Edge mode with a value above the modulus never compares, giving full duty.
// - Byte writes land in a buffer that moves to the compare value when both are in, at count 0 in edge and center modes.
// - Center select at 1 runs the counter up and down, modulus sets the period.
// - Center mode period is twice the modulus in timer clocks.
// - Center mode takes its polarity from the same polarity bit.
// - Center mode with a zero value or top bit set gives zero duty.
// - Center mode with a positive value above a nonzero modulus gives full duty.
// - Edge mode sets the channel flag when the count equals the channel value.
// - Center mode sets the channel flag on both matches of each period.
// - Edge PWM needs center select 0 and mode 1X; edge field 10 is high-true, X1 low-true.
// - The channel value clears to zero on reset.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.svh"
module tpc_top #(
   parameter int AW = 8
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic               pwm_out,
   output logic               pwm_oe,
   output logic               irq
);
   import tpc_pkg::*;

   logic [6:0]    ctrl_reg;
   tpc_word_t     mod_reg;
   logic          chflag_reg;
   logic          armed_reg;
   logic [1:0]    irq_stat_reg;
   logic [1:0]    irq_mask_reg;
   logic [AW-1:0] aw_addr_reg;
   logic          aw_held_reg;
   logic [31:0]   w_data_reg;
   logic [3:0]    w_strb_reg;
   logic          w_held_reg;
   tpc_word_t     count;
   tpc_word_t     chval;
   logic          down;
   logic          wrap;
   logic          pending;
   logic          wr_go;
   logic          wr_hit;
   logic          rd_go;
   logic          polarity_select_bit;
   logic          center_align_select;
   logic [1:0]    channel_mode_field;
   logic [1:0]    edge_level_field;
   tpc_mode_t     mode;
   logic          active;
   logic          match;
   logic          flag_wr_zero;

   // ****************************************************************
   // Control decode
   // ****************************************************************
   assign center_align_select = ctrl_reg[`TPC_CTRL_CAS];
   assign channel_mode_field  = ctrl_reg[`TPC_CTRL_MODE_HI:`TPC_CTRL_MODE_LO];
   assign edge_level_field    = ctrl_reg[`TPC_CTRL_EDGE_HI:`TPC_CTRL_EDGE_LO];
   assign polarity_select_bit = edge_level_field[0];

   // Edge field 00 releases the pin whatever the mode
   always_comb begin
      if (edge_level_field == 2'b00) mode = TPC_IDLE;
      else if (center_align_select) mode = TPC_CENTER;
      else if (channel_mode_field[1]) mode = TPC_EDGE;
      else mode = TPC_OTHER;
   end

   // ****************************************************************
   // Counter and channel value buffer
   // ****************************************************************
   tpc_counter #(.W(16)) u_cnt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (ctrl_reg[`TPC_CTRL_RUN]),
      .center  (center_align_select),
      .modulus (mod_reg),
      .count   (count),
      .down    (down),
      .wrap    (wrap)
   );

   // Non-PWM modes take a new value at once; PWM modes wait for count 0
   tpc_chan_buf u_buf (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_lo   (wr_hit && aw_addr_reg == `TPC_OFF_VAL_LO && w_strb_reg[0]),
      .wr_hi   (wr_hit && aw_addr_reg == `TPC_OFF_VAL_HI && w_strb_reg[0]),
      .wdata   (w_data_reg[7:0]),
      .load_ok ((mode != TPC_EDGE && mode != TPC_CENTER) || count == '0),
      .value   (chval),
      .pending (pending)
   );

   // ****************************************************************
   // PWM level
   // ****************************************************************
   // Level follows count against value; a positive value above the modulus never ends it
   always_comb begin
      if (mode == TPC_EDGE) begin
         active = (chval != '0) && (count < chval);
      end else if (mode == TPC_CENTER) begin
         if (chval == '0 || chval[15]) active = 1'b0;
         else if (down) active = (count <= chval);
         else active = (count < chval);
      end else begin
         active = 1'b0;
      end
   end

   // Registered pin; polarity flips the active level the same way in both modes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_out <= 1'b0;
         pwm_oe  <= 1'b0;
      end else begin
         pwm_oe  <= (mode == TPC_EDGE || mode == TPC_CENTER);
         pwm_out <= (mode == TPC_EDGE || mode == TPC_CENTER)
                    && (active ^ polarity_select_bit);
      end
   end

   // ****************************************************************
   // Channel flag
   // ****************************************************************
   // Every match counts; center mode meets the value twice a period
   assign match = ctrl_reg[`TPC_CTRL_RUN] && (mode == TPC_EDGE || mode == TPC_CENTER)
                  && count == chval;
   assign flag_wr_zero = wr_hit && aw_addr_reg == `TPC_OFF_CHFLAG
                         && w_strb_reg[0] && !w_data_reg[0];

   // Two-step clear; a match in the clearing cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chflag_reg <= 1'b0;
         armed_reg  <= 1'b0;
      end else begin
         if (match) chflag_reg <= 1'b1;
         else if (flag_wr_zero && armed_reg) chflag_reg <= 1'b0;
         if (rd_go && s_axi_araddr == `TPC_OFF_CHFLAG && chflag_reg) armed_reg <= 1'b1;
         else if (flag_wr_zero) armed_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************
   // Write one to clear; a new event in the same cycle stays set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= 2'h0;
      end else begin
         if (wr_hit && aw_addr_reg == `TPC_OFF_IRQ_STAT && w_strb_reg[0])
            irq_stat_reg <= irq_stat_reg & ~w_data_reg[1:0] | {wrap, match};
         else
            irq_stat_reg <= irq_stat_reg | {wrap, match};
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   // Address and data may come in either order; one write in flight at a time
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign wr_go  = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_hit = wr_go && (aw_addr_reg[1:0] == 2'b00) && (aw_addr_reg <= `TPC_OFF_IRQ_MASK)
                   && aw_addr_reg != `TPC_OFF_COUNT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         aw_addr_reg  <= '0;
         w_data_reg   <= 32'h0;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `TPC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control, modulus and mask registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg     <= `TPC_CTRL_RST;
         mod_reg      <= `TPC_MOD_RST;
         irq_mask_reg <= 2'h0;
      end else if (wr_hit) begin
         if (aw_addr_reg == `TPC_OFF_CTRL && w_strb_reg[0]) ctrl_reg <= w_data_reg[6:0];
         else if (aw_addr_reg == `TPC_OFF_MOD) begin
            if (w_strb_reg[0]) mod_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) mod_reg[15:8] <= w_data_reg[15:8];
         end else if (aw_addr_reg == `TPC_OFF_IRQ_MASK && w_strb_reg[0])
            irq_mask_reg <= w_data_reg[1:0];
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // Read data is captured at the address handshake, answered next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `TPC_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `TPC_RESP_OKAY;
         if (s_axi_araddr == `TPC_OFF_CTRL) s_axi_rdata <= {25'h0, ctrl_reg};
         else if (s_axi_araddr == `TPC_OFF_MOD) s_axi_rdata <= {16'h0, mod_reg};
         else if (s_axi_araddr == `TPC_OFF_VAL_LO) s_axi_rdata <= {24'h0, chval[7:0]};
         else if (s_axi_araddr == `TPC_OFF_VAL_HI) s_axi_rdata <= {24'h0, chval[15:8]};
         else if (s_axi_araddr == `TPC_OFF_COUNT) s_axi_rdata <= {16'h0, count};
         else if (s_axi_araddr == `TPC_OFF_CHFLAG) s_axi_rdata <= {30'h0, pending, chflag_reg};
         else if (s_axi_araddr == `TPC_OFF_IRQ_STAT) s_axi_rdata <= {30'h0, irq_stat_reg};
         else if (s_axi_araddr == `TPC_OFF_IRQ_MASK) s_axi_rdata <= {30'h0, irq_mask_reg};
         else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TPC_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic run;
   assign run = ctrl_reg[`TPC_CTRL_RUN];

   edge_overflow_a: assert property (
      mode == TPC_EDGE && chval != '0 && count == '0 |=> pwm_out == !polarity_select_bit)
      else $error("edge pwm not active after overflow");
   edge_zero_a: assert property (
      mode == TPC_EDGE && chval == '0 |=> pwm_out == polarity_select_bit)
      else $error("edge pwm active with zero value");
   edge_full_a: assert property (
      mode == TPC_EDGE && chval > mod_reg |=> pwm_out == !polarity_select_bit)
      else $error("edge pwm not full duty above modulus");
   load_hold_a: assert property (
      pending && count != '0 && (mode == TPC_EDGE || mode == TPC_CENTER) |=> $stable(chval))
      else $error("channel value moved away from count zero");
   center_period_a: assert property (
      (wrap && mode == TPC_CENTER && run && mod_reg == 16'h0002)
      ##1 (mode == TPC_CENTER && run && mod_reg == 16'h0002)[*4] |-> wrap)
      else $error("center period not twice the modulus");
   center_zero_a: assert property (
      mode == TPC_CENTER && (chval == '0 || chval[15]) |=> pwm_out == polarity_select_bit)
      else $error("center pwm active with zero or negative value");
   center_full_a: assert property (
      mode == TPC_CENTER && !chval[15] && mod_reg != '0 && chval > mod_reg
      |=> pwm_out == !polarity_select_bit)
      else $error("center pwm not full duty above modulus");
   center_down_a: assert property (
      mode == TPC_CENTER && down && count == chval && chval != '0 && !chval[15]
      |=> pwm_out == !polarity_select_bit)
      else $error("center pwm not active at down match");
   flag_set_a: assert property (
      match |=> chflag_reg)
      else $error("channel flag not set on match");
   flag_keep_a: assert property (
      chflag_reg && !armed_reg && !match |=> chflag_reg)
      else $error("channel flag cleared without prior read");
   pin_idle_a: assert property (
      mode == TPC_IDLE || mode == TPC_OTHER |=> !pwm_oe && !pwm_out)
      else $error("pin driven outside pwm mode");

   edge_cycle_c: cover property (mode == TPC_EDGE && run && wrap ##[1:40] match);
   center_twice_c: cover property (mode == TPC_CENTER && match ##[1:80] match);
   flag_clear_c: cover property (chflag_reg && armed_reg ##1 !chflag_reg);
endmodule
`default_nettype wire

/* src/tpc_defines.svh */
// Register offsets, field positions and reset values of the timer PWM channel.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TPC_OFF_CTRL     8'h00
`define TPC_OFF_MOD      8'h04
`define TPC_OFF_VAL_LO   8'h08
`define TPC_OFF_VAL_HI   8'h0C
`define TPC_OFF_COUNT    8'h10
`define TPC_OFF_CHFLAG   8'h14
`define TPC_OFF_IRQ_STAT 8'h18
`define TPC_OFF_IRQ_MASK 8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define TPC_CTRL_CAS     0
`define TPC_CTRL_MODE_LO 2
`define TPC_CTRL_MODE_HI 3
`define TPC_CTRL_EDGE_LO 4
`define TPC_CTRL_EDGE_HI 5
`define TPC_CTRL_RUN     6
`define TPC_IRQ_MATCH    0
`define TPC_IRQ_WRAP     1

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define TPC_CTRL_RST     7'h00
`define TPC_MOD_RST      16'hFFFF
`define TPC_VAL_RST      16'h0000
`define TPC_RESP_OKAY    2'h0
`define TPC_RESP_SLVERR  2'h2

`endif

/* src/tpc_pkg.sv */
// Types shared by the timer PWM channel modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tpc_pkg;
   typedef logic [15:0] tpc_word_t;
   typedef logic [7:0]  tpc_byte_t;
   // Channel operating mode decoded from the control bits
   typedef enum logic [1:0] {TPC_IDLE, TPC_EDGE, TPC_CENTER, TPC_OTHER} tpc_mode_t;
endpackage

/* src/tpc_counter.sv */
// Timer counter: up-counting modulo counter or up/down counter.
// Assumes run, center and modulus come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module tpc_counter #(
   parameter int W = 16
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         run,
   input  wire logic         center,
   input  wire logic [W-1:0] modulus,
   output logic      [W-1:0] count,
   output logic              down,
   output logic              wrap
);
   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

   // ****************************************************************
   // Counting
   // ****************************************************************
   // Center mode runs 0..mod..1 so a period is twice the modulus
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         down  <= 1'b0;
      end else if (run) begin
         if (!center) begin
            down  <= 1'b0;
            count <= (count >= modulus) ? '0 : count + ONE;
         end else if (modulus == '0) begin
            count <= '0;
            down  <= 1'b0;
         end else if (!down) begin
            if (count >= modulus) begin
               down  <= 1'b1; // Also catches a modulus lowered below the count
               count <= count - ONE;
            end else begin
               count <= count + ONE;
            end
         end else begin
            count <= (count == '0) ? ONE : count - ONE;
            if (count <= ONE) down <= 1'b0;
         end
      end
   end

   // Pulse when edge counting reaches the modulus, or when center counting steps down from 1 to 0
   assign wrap = run && (center ? (down && count == ONE)
                                : (count >= modulus));
endmodule
`default_nettype wire

/* src/tpc_chan_buf.sv */
// Double buffer for the 16-bit channel value written as two bytes.
// Assumes single-cycle write strobes and a load permission from the timer.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.svh"
module tpc_chan_buf (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              wr_lo,
   input  wire logic              wr_hi,
   input  wire tpc_pkg::tpc_byte_t wdata,
   input  wire logic              load_ok,
   output tpc_pkg::tpc_word_t     value,
   output logic                   pending
);
   import tpc_pkg::*;

   tpc_word_t buf_reg;
   logic      lo_done_reg;
   logic      hi_done_reg;

   // ****************************************************************
   // Byte capture
   // ****************************************************************
   // A byte write never touches the live compare value directly
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buf_reg     <= `TPC_VAL_RST;
         lo_done_reg <= 1'b0;
         hi_done_reg <= 1'b0;
      end else begin
         if (wr_lo) buf_reg[7:0] <= wdata;
         if (wr_hi) buf_reg[15:8] <= wdata;
         if (pending && load_ok) begin
            lo_done_reg <= 1'b0;
            hi_done_reg <= 1'b0;
         end else begin
            if (wr_lo) lo_done_reg <= 1'b1;
            if (wr_hi) hi_done_reg <= 1'b1;
         end
      end
   end

   assign pending = lo_done_reg && hi_done_reg;

   // Transfer only once both halves are in, so no torn 16-bit value
   always_ff @(posedge aclk) begin
      if (!aresetn) value <= `TPC_VAL_RST;
      else if (pending && load_ok) value <= buf_reg;
   end
endmodule
`default_nettype wire

/* tb/tpc_top_bench.sv */
// Self-checking bench for the timer PWM channel top level.
// Assumes tpc_pkg, tpc_defines.svh and tpc_top from src/ on the compile path.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.svh"
module tpc_top_bench;
   import tpc_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        pwm_out, pwm_oe, irq;
   int          errors = 0;
   int          checked = 0;
   // Mode tables: control byte, channel value (center only, edge uses 4), expected active cycles
   logic [7:0]  ec [4] = '{8'h68, 8'h6C, 8'h58, 8'h78};
   int          eh [4] = '{4, 4, 6, 6};
   logic [7:0]  cc [5] = '{8'h61, 8'h51, 8'h61, 8'h61, 8'h61};
   logic [15:0] cv [5] = '{16'h0003, 16'h0003, 16'h8005, 16'h0009, 16'h0000};
   int          ch [5] = '{6, 10, 0, 16, 0};

   tpc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out, .pwm_oe, .irq);

   // 10 MHz clock
   always #50 aclk = ~aclk;

   // ****************************************************************
   // Bus and compare tasks
   // ****************************************************************
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      // One idle edge keeps bready from being lowered and raised in one step
      @(posedge aclk);
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge aclk);
   endtask

   // Let a pending value settle, then count active cycles over one period
   task duty(input int n, input int e);
      int h;
      h = 0;
      repeat (2 * n + 4) @(posedge aclk);
      repeat (n) begin
         @(posedge aclk);
         h += (pwm_out === 1'b1);
      end
      chk("active cycles", e, h);
   endtask

   task pw(input logic [7:0] c, input logic [15:0] v, input int n, input int e);
      wr(`TPC_OFF_CTRL, {24'h0, c}, `TPC_RESP_OKAY);
      wr(`TPC_OFF_VAL_LO, {24'h0, v[7:0]}, `TPC_RESP_OKAY);
      wr(`TPC_OFF_VAL_HI, {24'h0, v[15:8]}, `TPC_RESP_OKAY);
      duty(n, e);
   endtask

   task results;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] d;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`TPC_OFF_VAL_HI, d, `TPC_RESP_OKAY);
      chk("value high", 32'h0, {24'h0, d[7:0]});
      rd(`TPC_OFF_MOD, d, `TPC_RESP_OKAY);
      chk("modulus", 32'hFFFF, {16'h0, d[15:0]});
      chk("pin enable", 32'h0, {31'h0, pwm_oe});
      // Edge mode, period 10, every polarity and mode code
      wr(`TPC_OFF_MOD, 32'h9, `TPC_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         pw(ec[i], 16'h0004, 10, eh[i]);
      end
      pw(8'h68, 16'h0004, 10, 4);
      chk("pin enable", 32'h1, {31'h0, pwm_oe});
      // Flag clear needs a read of the set flag first; counter stopped, never read yet
      wr(`TPC_OFF_CTRL, 32'h28, `TPC_RESP_OKAY);
      wr(`TPC_OFF_CHFLAG, 32'h1, `TPC_RESP_OKAY);
      wr(`TPC_OFF_CHFLAG, 32'h0, `TPC_RESP_OKAY);
      rd(`TPC_OFF_CHFLAG, d, `TPC_RESP_OKAY);
      chk("flag kept", 32'h1, {31'h0, d[0]});
      wr(`TPC_OFF_CHFLAG, 32'h0, `TPC_RESP_OKAY);
      rd(`TPC_OFF_CHFLAG, d, `TPC_RESP_OKAY);
      chk("flag cleared", 32'h0, {31'h0, d[0]});
      wr(`TPC_OFF_CTRL, 32'h68, `TPC_RESP_OKAY);
      // Half-written value must not reach the compare
      wr(`TPC_OFF_VAL_LO, 32'h7, `TPC_RESP_OKAY);
      duty(10, 4);
      rd(`TPC_OFF_CHFLAG, d, `TPC_RESP_OKAY);
      chk("flag and pending", 32'h1, {30'h0, d[1:0]});
      wr(`TPC_OFF_VAL_HI, 32'h0, `TPC_RESP_OKAY);
      duty(10, 7);
      pw(8'h68, 16'h0000, 10, 0);
      pw(8'h68, 16'h000A, 10, 10);
      wr(`TPC_OFF_CTRL, 32'h48, `TPC_RESP_OKAY);
      chk("pin enable off", 32'h0, {31'h0, pwm_oe});
      // Mode field 00 outside center select is no PWM mode either
      wr(`TPC_OFF_CTRL, 32'h60, `TPC_RESP_OKAY);
      chk("pin enable other", 32'h0, {31'h0, pwm_oe});
      // Interrupt raised, masked and cleared
      rd(`TPC_OFF_IRQ_STAT, d, `TPC_RESP_OKAY);
      chk("match status", 32'h1, {31'h0, d[0]});
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`TPC_OFF_IRQ_MASK, 32'h1, `TPC_RESP_OKAY);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`TPC_OFF_IRQ_STAT, 32'h1, `TPC_RESP_OKAY);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // Refused accesses
      wr(8'h20, 32'h5, `TPC_RESP_SLVERR);
      wr(`TPC_OFF_COUNT, 32'h5, `TPC_RESP_SLVERR);
      rd(8'h24, d, `TPC_RESP_SLVERR);
      // Center mode, modulus 8 gives a 16-cycle period
      wr(`TPC_OFF_MOD, 32'h8, `TPC_RESP_OKAY);
      for (int i = 0; i < 5; i++) begin
         pw(cc[i], cv[i], 16, ch[i]);
      end
      // Stop the counter so no compare races the two-step clear
      wr(`TPC_OFF_CTRL, 32'h21, `TPC_RESP_OKAY);
      rd(`TPC_OFF_CHFLAG, d, `TPC_RESP_OKAY);
      chk("center flag", 32'h1, {31'h0, d[0]});
      wr(`TPC_OFF_CHFLAG, 32'h0, `TPC_RESP_OKAY);
      rd(`TPC_OFF_CHFLAG, d, `TPC_RESP_OKAY);
      chk("center flag", 32'h0, {31'h0, d[0]});
      pw(8'h61, 16'h0003, 16, 6);
      rd(`TPC_OFF_CHFLAG, d, `TPC_RESP_OKAY);
      chk("center flag", 32'h1, {31'h0, d[0]});
      // Shrink the modulus while edge counting so the count never exceeds it
      wr(`TPC_OFF_CTRL, 32'h48, `TPC_RESP_OKAY);
      wr(`TPC_OFF_MOD, 32'h2, `TPC_RESP_OKAY);
      wr(`TPC_OFF_CTRL, 32'h61, `TPC_RESP_OKAY);
      duty(4, 4);
      results();
   end

   // Watchdog well beyond the thousand or so cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      results();
   end
endmodule
`default_nettype wire
